// >>> pkg/ccsr_pkg.sv
// constants, register map and types of the converter control and status registers
package ccsr_pkg;
	localparam logic [7:0] ADDR_PAD     = 8'h06;
	localparam logic [7:0] ADDR_IFC     = 8'h07;
	localparam logic [7:0] ADDR_KEY     = 8'h08;
	localparam logic [7:0] ADDR_MASK    = 8'h09;
	localparam logic [7:0] ADDR_STATUS  = 8'h0a;
	localparam logic [7:0] ADDR_FLAGS   = 8'h0b;
	localparam logic [7:0] ADDR_LOG     = 8'h0c;
	localparam logic [7:0] ADDR_LOCK    = 8'h0d;
	localparam logic [7:0] ADDR_THRESH  = 8'h0e;
	localparam logic [7:0] ADDR_LOCK_LO = 8'h0e;
	localparam logic [7:0] ADDR_LOCK_HI = 8'h2f;
	localparam logic [7:0] LOCK_KEY     = 8'h4a;
	localparam logic [7:0] RST_PAD      = 8'hbb;
	localparam logic [7:0] RST_IFC      = 8'h13;
	localparam logic [7:0] RST_KEY      = 8'h23;
	localparam logic [7:0] RST_THRESH   = 8'ha5;
	localparam logic [7:0] RST_ZERO     = 8'h00;
	localparam int LOG_KEY_BIT = 4;
	localparam int FLAG_KEY_RESET = 7;
	localparam int CLK_PERIOD_NS = 50;
	localparam int DEGLITCH_NS = 50;
	localparam int DEGLITCH_CYCLES = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_US = 125;
	localparam int TICK_CYCLES_DEF = TICK_US * 1000 / CLK_PERIOD_NS;
	localparam int SCL_TIMEOUT_MS = 35;
	localparam int SCL_TIMEOUT_CYCLES_DEF = SCL_TIMEOUT_MS * 1_000_000 / CLK_PERIOD_NS;
	localparam int PWR_CYCLE_DELAY_MS = 1000;
	localparam int PWR_CYCLE_TICKS = PWR_CYCLE_DELAY_MS * 1000 / TICK_US;
	localparam int DB_W = 13;
	localparam int HOLD_W = 17;
	localparam int DEBOUNCE_US [8] = '{0, 125, 1000, 10000, 30000, 250000, 500000, 750000};
	localparam int KEY_DELAY_MS [4] = '{1000, 1500, 2000, 7000};
	localparam int SHUT_EXTRA_MS [4] = '{0, 4000, 5000, 6000};

	typedef enum logic [2:0] {
		FN_GPI  = 3'b000,
		FN_EN   = 3'b001,
		FN_SLP  = 3'b010,
		FN_PWC  = 3'b011,
		FN_GPO  = 3'b100,
		FN_PG   = 3'b101,
		FN_IRQ  = 3'b110,
		FN_CLK  = 3'b111
	} ccsr_pin_func_type;

	typedef enum logic [1:0] {
		LP_IDLE    = 2'b00,
		LP_HOLD    = 2'b01,
		LP_ARMED   = 2'b10,
		LP_RELEASE = 2'b11
	} ccsr_lp_state_type;

	typedef struct packed {
		logic pulldown_en;
		logic pullup_en;
		logic mode;
		logic polarity;
	} ccsr_pin_cfg_type;

	typedef struct packed {
		logic       write_mode;
		logic       serial_highspeed_always;
		logic       pc_done;
		logic       serial_timeout_en;
		logic       deglitch_en;
		logic [2:0] input_debounce_sel;
	} ccsr_ifc_type;

	typedef struct packed {
		logic [1:0] shut_delay;
		logic [1:0] key_delay;
		logic       key_edge_select;
		logic [2:0] key_debounce_sel;
	} ccsr_key_type;

	function automatic logic [DB_W-1:0] db_ticks(input logic [2:0] sel);
		db_ticks = DB_W'(DEBOUNCE_US[sel] / TICK_US);
	endfunction

	function automatic logic [HOLD_W-1:0] hold_ticks(input logic [1:0] kd, input logic [1:0] sd);
		hold_ticks = HOLD_W'((KEY_DELAY_MS[kd] + SHUT_EXTRA_MS[sd]) * 1000 / TICK_US);
	endfunction
endpackage

// >>> logic/ccsr_top.sv
// control and status register bank with pad, key and event logic
`timescale 1ns/1ps
`default_nettype none
module ccsr_top
	import ccsr_pkg::*;
#(
	parameter int TICK_CYCLES        = ccsr_pkg::TICK_CYCLES_DEF,
	parameter int SCL_TIMEOUT_CYCLES = ccsr_pkg::SCL_TIMEOUT_CYCLES_DEF
) (
	input  wire logic                        CLK,
	input  wire logic                        RST_B,
	input  wire logic                        CE,
	input  wire logic [7:0]                  REG_ADDR,
	input  wire logic [7:0]                  REG_WDATA,
	input  wire logic                        REG_WR,
	input  wire logic                        REG_RD,
	output var  logic [7:0]                  REG_RDATA,
	input  wire logic                        SCL_IN,
	output var  logic                        SERIAL_IF_RESET,
	output var  logic                        SERIAL_HS_ALWAYS,
	input  wire ccsr_pkg::ccsr_pin_func_type PIN0_FUNC,
	input  wire ccsr_pkg::ccsr_pin_func_type PIN1_FUNC,
	input  wire logic [1:0]                  PIN_IN,
	output var  logic [1:0]                  PIN_OUT,
	output var  logic [1:0]                  PIN_OE,
	output var  logic [1:0]                  PIN_PU_EN,
	output var  logic [1:0]                  PIN_PD_EN,
	output var  logic                        PIN_FUNC_ENABLE,
	output var  logic                        PIN_FUNC_SLEEP,
	output var  logic                        PIN_FUNC_PWRCYC,
	input  wire logic                        POWER_BUTTON_N,
	input  wire logic                        BUTTON_ENABLE_MODE,
	output var  logic                        KEY_CHIP_ENABLE,
	input  wire logic                        OC_WARN,
	input  wire logic                        TEMP_WARN,
	input  wire logic                        VBAT_WARN,
	input  wire logic                        OUTPUT_IN_RANGE,
	input  wire logic [7:0]                  CAUSE_SET,
	output var  logic                        PWR_CYCLE_REQ,
	output var  logic [7:0]                  THRESHOLD_CONFIG,
	output var  logic                        INTERRUPT_OUT_N
);
	import ccsr_pkg::*;

	localparam int TICK_W = $clog2(TICK_CYCLES + 1);
	localparam int TO_W = $clog2(SCL_TIMEOUT_CYCLES + 2);

	ccsr_pin_cfg_type [1:0]  pad;
	ccsr_ifc_type            ifc;
	ccsr_key_type            keyc;
	logic [6:0]              mask;
	logic [7:0]              flags;
	logic [7:0]              cause_log;
	logic                    unlocked;
	logic [7:0]              thresh;
	logic [7:0]              next_flags;
	logic [7:0]              flag_set;
	logic [7:0]              flag_clr;
	logic                    next_irq;
	logic                    wr_ok;
	logic [6:0]              sync1;
	logic [6:0]              sync2;
	logic                    pin0_prev;
	logic [2:0]              db_raw;
	logic [2:0]              db_en;
	logic [2:0]              db_sel [3];
	logic [2:0]              db_lvl;
	logic [2:0]              db_prev;
	logic [DB_W-1:0]         db_cnt [3];
	logic [4:0]              warn_prev;
	logic [TICK_W-1:0]       tick_cnt;
	logic                    tick;
	logic [TO_W-1:0]         scl_low_cnt;
	ccsr_lp_state_type       lp_state;
	logic [HOLD_W-1:0]       hold_cnt;
	logic [HOLD_W-1:0]       pc_cnt;
	logic                    lp_hit;
	logic                    pc_fire;
	logic [1:0]              pin_out_fn;
	logic [1:0]              pin_active;
	logic [1:0]              pin_is_in;
	logic                    key_pressed;
	logic                    button_edge;

	// in-range is inverted so its falling edge shares the rising-edge detector
	assign wr_ok = REG_WR && CE;
	assign key_pressed = !db_lvl[2];

	// analog and pin levels arrive asynchronously
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			// clock and key pins idle high, so no false low follows reset
			sync1 <= 7'h60;
			sync2 <= 7'h60;
			pin0_prev <= 1'b0;
		end else if (CE) begin
			sync1 <= {SCL_IN, POWER_BUTTON_N, OC_WARN, TEMP_WARN, VBAT_WARN, PIN_IN};
			sync2 <= sync1;
			pin0_prev <= sync2[0];
		end
	end

	// pin 0 filter: a level must hold one extra sample before it is accepted
	assign db_raw[0] = (ifc.deglitch_en && sync2[0] != pin0_prev) ? db_lvl[0] : sync2[0];
	assign db_raw[1] = sync2[1];
	assign db_raw[2] = sync2[5];
	assign db_en = {1'b1, pad[1].mode, pad[0].mode};
	assign db_sel[0] = ifc.input_debounce_sel;
	assign db_sel[1] = ifc.input_debounce_sel;
	assign db_sel[2] = keyc.key_debounce_sel;

	// shared time base keeps the long counters narrow
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			tick_cnt <= '0;
		end else if (CE) begin
			tick_cnt <= tick ? '0 : tick_cnt + TICK_W'(1);
		end
	end
	assign tick = tick_cnt == TICK_W'(TICK_CYCLES - 1);

	generate
		for (genvar ch = 0; ch < 3; ch++) begin : g_db
			always_ff @(posedge CLK or negedge RST_B) begin
				if (!RST_B) begin
					db_lvl[ch] <= 1'(ch == 2);
					db_prev[ch] <= 1'(ch == 2);
					db_cnt[ch] <= '0;
				end else if (CE) begin
					db_prev[ch] <= db_lvl[ch];
					if (!db_en[ch] || db_ticks(db_sel[ch]) == '0) begin
						db_lvl[ch] <= db_raw[ch];
						db_cnt[ch] <= '0;
					end else if (db_raw[ch] == db_lvl[ch]) begin
						db_cnt[ch] <= '0;
					end else if (tick) begin
						if (db_cnt[ch] + DB_W'(1) >= db_ticks(db_sel[ch])) begin
							db_lvl[ch] <= db_raw[ch];
							db_cnt[ch] <= '0;
						end else begin
							db_cnt[ch] <= db_cnt[ch] + DB_W'(1);
						end
					end
				end
			end
		end
	endgenerate

	// pad drive per pin
	generate
		for (genvar p = 0; p < 2; p++) begin : g_pad
			ccsr_pin_func_type fn;
			logic lvl;
			assign fn = (p == 0) ? PIN0_FUNC : PIN1_FUNC;
			assign pin_is_in[p] = !(fn inside {FN_GPO, FN_PG, FN_IRQ});
			assign pin_active[p] = pad[p].polarity ? db_lvl[p] : !db_lvl[p];
			// good and interrupt levels, active high before the polarity bit
			assign pin_out_fn[p] = (fn == FN_PG) ? !warn_prev[0] : !INTERRUPT_OUT_N;
			always_comb begin
				if (pin_is_in[p]) begin
					lvl = 1'b0;
				end else if (fn == FN_GPO) begin
					lvl = pad[p].polarity;
				end else begin
					lvl = pad[p].polarity ? pin_out_fn[p] : !pin_out_fn[p];
				end
			end
			always_ff @(posedge CLK or negedge RST_B) begin
				if (!RST_B) begin
					PIN_OUT[p] <= 1'b0;
					PIN_OE[p] <= 1'b0;
					PIN_PU_EN[p] <= 1'b0;
					PIN_PD_EN[p] <= 1'b0;
				end else if (CE) begin
					PIN_OUT[p] <= lvl && pad[p].mode;
					PIN_OE[p] <= !pin_is_in[p] && (pad[p].mode || !lvl);
					PIN_PD_EN[p] <= pad[p].pulldown_en && pin_is_in[p];
					PIN_PU_EN[p] <= pad[p].pullup_en && (pin_is_in[p] || !pad[p].mode);
				end
			end
		end
	endgenerate

	// input functions: pin 0 shadows pin 1 when both pick the same one
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			PIN_FUNC_ENABLE <= 1'b0;
			PIN_FUNC_SLEEP <= 1'b0;
			PIN_FUNC_PWRCYC <= 1'b0;
		end else if (CE) begin
			PIN_FUNC_ENABLE <= (PIN0_FUNC == FN_EN) ? pin_active[0] :
				(PIN1_FUNC == FN_EN) && pin_active[1];
			PIN_FUNC_SLEEP <= (PIN0_FUNC == FN_SLP) ? pin_active[0] :
				(PIN1_FUNC == FN_SLP) && pin_active[1];
			PIN_FUNC_PWRCYC <= (PIN0_FUNC == FN_PWC) ? pin_active[0] :
				(PIN1_FUNC == FN_PWC) && pin_active[1];
		end
	end

	// serial clock stuck-low watchdog
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			scl_low_cnt <= '0;
			SERIAL_IF_RESET <= 1'b0;
		end else if (CE) begin
			SERIAL_IF_RESET <= ifc.serial_timeout_en && !sync2[6] &&
				scl_low_cnt == TO_W'(SCL_TIMEOUT_CYCLES);
			if (!ifc.serial_timeout_en || sync2[6]) begin
				scl_low_cnt <= '0;
			end else if (scl_low_cnt != TO_W'(SCL_TIMEOUT_CYCLES + 1)) begin
				scl_low_cnt <= scl_low_cnt + TO_W'(1);
			end
		end
	end
	assign SERIAL_HS_ALWAYS = ifc.serial_highspeed_always;

	// long press and delayed power cycle
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			lp_state <= LP_IDLE;
			hold_cnt <= '0;
			pc_cnt <= '0;
		end else if (CE) begin
			unique case (lp_state)
				LP_IDLE: begin
					hold_cnt <= '0;
					if (!BUTTON_ENABLE_MODE && keyc.shut_delay != 2'b00 && key_pressed) begin
						lp_state <= LP_HOLD;
					end
				end
				LP_HOLD: begin
					if (BUTTON_ENABLE_MODE || keyc.shut_delay == 2'b00 || !key_pressed) begin
						lp_state <= LP_IDLE;
					end else if (lp_hit) begin
						lp_state <= LP_ARMED;
						pc_cnt <= '0;
					end else if (tick) begin
						hold_cnt <= hold_cnt + HOLD_W'(1);
					end
				end
				LP_ARMED: begin
					if (!flags[FLAG_KEY_RESET] || pc_fire) begin
						lp_state <= LP_RELEASE;
					end else if (tick) begin
						pc_cnt <= pc_cnt + HOLD_W'(1);
					end
				end
				LP_RELEASE: begin
					if (!key_pressed) begin
						lp_state <= LP_IDLE;
					end
				end
			endcase
		end
	end
	assign lp_hit = lp_state == LP_HOLD && tick && key_pressed && !BUTTON_ENABLE_MODE &&
		keyc.shut_delay != 2'b00 &&
		hold_cnt + HOLD_W'(1) >= hold_ticks(keyc.key_delay, keyc.shut_delay);
	assign pc_fire = lp_state == LP_ARMED && flags[FLAG_KEY_RESET] && tick &&
		pc_cnt + HOLD_W'(1) >= HOLD_W'(PWR_CYCLE_TICKS);

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			PWR_CYCLE_REQ <= 1'b0;
			KEY_CHIP_ENABLE <= 1'b1;
			warn_prev <= '0;
		end else if (CE) begin
			PWR_CYCLE_REQ <= pc_fire;
			KEY_CHIP_ENABLE <= !BUTTON_ENABLE_MODE || db_lvl[2];
			warn_prev <= {sync2[4:2], 1'b0, !OUTPUT_IN_RANGE};
		end
	end

	// outside button-enable mode the edge picked by the select bit raises the key event
	assign button_edge = !BUTTON_ENABLE_MODE && db_lvl[2] != db_prev[2] &&
		db_lvl[2] == keyc.key_edge_select;
	assign flag_set = {lp_hit,
		sync2[3] && !warn_prev[3], sync2[2] && !warn_prev[2], button_edge,
		sync2[4] && !warn_prev[4], !OUTPUT_IN_RANGE && !warn_prev[0],
		pin_is_in[1] && pin_active[1] && db_lvl[1] != db_prev[1],
		pin_is_in[0] && pin_active[0] && db_lvl[0] != db_prev[0]};
	assign flag_clr = (wr_ok && REG_ADDR == ADDR_FLAGS) ? REG_WDATA : '0;
	assign next_flags = (flags & ~flag_clr) | flag_set;
	assign next_irq = |(next_flags & {1'b1, ~mask});

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			flags <= RST_ZERO;
			INTERRUPT_OUT_N <= 1'b1;
		end else if (CE) begin
			flags <= next_flags;
			INTERRUPT_OUT_N <= !next_irq;
		end
	end

	// register writes
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			pad <= RST_PAD;
			ifc <= RST_IFC;
			keyc <= RST_KEY;
			mask <= RST_ZERO[6:0];
			cause_log <= RST_ZERO;
			unlocked <= 1'b0;
			thresh <= RST_THRESH;
		end else if (CE) begin
			cause_log <= ((wr_ok && REG_ADDR == ADDR_LOG) ? REG_WDATA : cause_log) |
				CAUSE_SET | (8'(pc_fire) << LOG_KEY_BIT);
			if (wr_ok) begin
				unique case (REG_ADDR)
					ADDR_PAD:    pad <= REG_WDATA;
					ADDR_IFC:    ifc <= REG_WDATA;
					ADDR_KEY:    keyc <= REG_WDATA;
					ADDR_MASK:   mask <= REG_WDATA[6:0];
					ADDR_LOCK:   unlocked <= REG_WDATA == LOCK_KEY;
					ADDR_THRESH: if (unlocked) thresh <= REG_WDATA;
					default:     ;
				endcase
			end
		end
	end
	assign THRESHOLD_CONFIG = thresh;

	// register reads, one cycle after the strobe
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			REG_RDATA <= RST_ZERO;
		end else if (CE && REG_RD) begin
			unique case (REG_ADDR)
				ADDR_PAD:    REG_RDATA <= pad;
				ADDR_IFC:    REG_RDATA <= ifc;
				ADDR_KEY:    REG_RDATA <= keyc;
				ADDR_MASK:   REG_RDATA <= {1'b0, mask};
				ADDR_STATUS: REG_RDATA <= {sync2[4:2], 1'b0, key_pressed,
					OUTPUT_IN_RANGE, db_lvl[1:0]};
				ADDR_FLAGS:  REG_RDATA <= flags;
				ADDR_LOG:    REG_RDATA <= cause_log;
				ADDR_LOCK:   REG_RDATA <= unlocked ? LOCK_KEY : RST_ZERO;
				ADDR_THRESH: REG_RDATA <= thresh;
				default:     REG_RDATA <= RST_ZERO;
			endcase
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	irq_level_a: assert property (CE |=> INTERRUPT_OUT_N == !(|(flags & {1'b1, ~$past(mask)})))
		else $error("interrupt output disagrees with flags and mask");
	w1c_clear_a: assert property (CE && wr_ok && REG_ADDR == ADDR_FLAGS && REG_WDATA[5] &&
		!flag_set[5] |=> !flags[5])
		else $error("write one did not clear flag");
	w0_keep_a: assert property (CE && !(wr_ok && REG_ADDR == ADDR_FLAGS && REG_WDATA[6]) &&
		flags[6] |=> flags[6])
		else $error("flag lost without write one");
	lock_read_a: assert property (CE && REG_RD && REG_ADDR == ADDR_LOCK && !unlocked
		|=> REG_RDATA == 8'h00)
		else $error("lock register nonzero while locked");
	locked_write_a: assert property (CE && wr_ok && REG_ADDR == ADDR_THRESH && !unlocked
		|=> $stable(thresh))
		else $error("locked region accepted a write");
	pulldown_out_a: assert property (CE && !pin_is_in[1] |=> !PIN_PD_EN[1])
		else $error("pull-down on while pin drives");
	pullup_pp_a: assert property (CE && !pin_is_in[1] && pad[1].mode |=> !PIN_PU_EN[1])
		else $error("pull-up on for push-pull output");
	scl_reset_a: assert property ($rose(SERIAL_IF_RESET) |->
		$past(scl_low_cnt) == TO_W'(SCL_TIMEOUT_CYCLES))
		else $error("serial reset without full low time");
	key_edge_a: assert property (CE && !BUTTON_ENABLE_MODE && db_prev[2] != keyc.key_edge_select &&
		db_lvl[2] == keyc.key_edge_select |=> flags[4])
		else $error("selected key edge did not latch the key event");
	pwr_cycle_a: assert property (PWR_CYCLE_REQ |-> $past(lp_state) == LP_ARMED &&
		$past(flags[FLAG_KEY_RESET]))
		else $error("power cycle without armed long press");
	cause_log_a: assert property (CE && pc_fire |=> cause_log[LOG_KEY_BIT])
		else $error("long press cause not logged");

	long_press_c: cover property (lp_state == LP_ARMED && pc_fire ##1 PWR_CYCLE_REQ);
	cancel_c: cover property (lp_state == LP_ARMED ##1 !flags[FLAG_KEY_RESET]);
	unlock_write_c: cover property (unlocked && wr_ok && REG_ADDR == ADDR_THRESH);
	irq_c: cover property ($fell(INTERRUPT_OUT_N));
endmodule
`default_nettype wire

// >>> sim/ccsr_button_model.sv
// push-button partner that holds the key pin at a level for a number of cycles
`timescale 1ns/1ps
`default_nettype none
module ccsr_button_model (
	input  wire logic clk,
	output var  logic key_n
);
	initial key_n = 1'b1;
	// a short hold between long ones acts as contact chatter
	task automatic hold(input logic lvl, input int n);
		@(negedge clk);
		key_n = lvl;
		repeat (n) @(negedge clk);
	endtask
endmodule
`default_nettype wire

// >>> sim/ccsr_top_bench.sv
// self-checking bench of the control and status register bank
`timescale 1ns/1ps
`default_nettype none
module ccsr_top_bench;
	import ccsr_pkg::*;
	logic              clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
	logic              scl = 1'b1, oc = 1'b0, tmp = 1'b0, vb = 1'b0, en_mode = 1'b0;
	logic [7:0]        addr = 8'h00, wdata = 8'h00, cause = 8'h00, exp_f, rdata, thr;
	logic [1:0]        pin_in = 2'b00, pout, poe, ppu, ppd;
	logic [2:0]        pw = 3'b000;
	logic              ce = 1'b1, pg = 1'b1;
	logic [2:0]        fo;
	logic              if_rst, hs, key_n, key_ce, pc_req, irq_n;
	ccsr_pin_func_type f0 = FN_GPI, f1 = FN_GPO;
	logic [7:0]        exp_q [$];
	logic [31:0]       seed = 32'hc8da_53e7;
	int                miscompares = 0, n_tests = 0, pulses = 0, n;
	logic [7:0]        ra [9] = '{ADDR_PAD, ADDR_IFC, ADDR_KEY, ADDR_MASK, ADDR_FLAGS,
		ADDR_LOG, ADDR_LOCK, ADDR_THRESH, 8'h40};
	logic [7:0]        rv [9] = '{RST_PAD, RST_IFC, RST_KEY, RST_ZERO, RST_ZERO,
		RST_ZERO, RST_ZERO, RST_THRESH, RST_ZERO};
	logic [3:0]        pn [4] = '{4'hc, 4'h5, 4'h3, 4'h2};
	logic [3:0]        pe [4] = '{4'b1010, 4'b0010, 4'b1100, 4'b1000};

	// short tick and timeout so the long-press path fits in the run
	ccsr_top #(.TICK_CYCLES(1), .SCL_TIMEOUT_CYCLES(20)) DUT (
		.CLK(clk), .RST_B(rst_b), .CE(ce), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .SCL_IN(scl),
		.SERIAL_IF_RESET(if_rst), .SERIAL_HS_ALWAYS(hs), .PIN0_FUNC(f0),
		.PIN1_FUNC(f1), .PIN_IN(pin_in), .PIN_OUT(pout), .PIN_OE(poe),
		.PIN_PU_EN(ppu), .PIN_PD_EN(ppd), .PIN_FUNC_ENABLE(fo[0]), .PIN_FUNC_SLEEP(fo[1]),
		.PIN_FUNC_PWRCYC(fo[2]), .POWER_BUTTON_N(key_n), .BUTTON_ENABLE_MODE(en_mode),
		.KEY_CHIP_ENABLE(key_ce), .OC_WARN(oc), .TEMP_WARN(tmp), .VBAT_WARN(vb),
		.OUTPUT_IN_RANGE(pg), .CAUSE_SET(cause), .PWR_CYCLE_REQ(pc_req),
		.THRESHOLD_CONFIG(thr), .INTERRUPT_OUT_N(irq_n)
	);
	ccsr_button_model btn (.clk(clk), .key_n(key_n));

	initial forever #25 clk = ~clk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (e !== g) begin
			miscompares++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	// one access; a read leaves its expected value for the watcher
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = w;
		rd = !w;
		if (!w) exp_q.push_back(d);
		@(negedge clk);
		wr = 1'b0;
		rd = 1'b0;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask

	task automatic wrap_up;
		$display("compares %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	always @(posedge clk) rd_d <= rd;
	always @(posedge clk) if (if_rst === 1'b1) pulses <= pulses + 1;
	// read data is settled by the falling edge after the read was taken
	always @(negedge clk) if (rd_d) chk(exp_q.pop_front(), rdata);

	initial begin
		repeat (10) @(posedge clk);
		@(negedge clk);
		rst_b = 1'b1;
		cyc(100);
		foreach (ra[i]) bus(1'b0, ra[i], rv[i]);
		bus(1'b1, ADDR_THRESH, 8'h12);
		chk(RST_THRESH, thr);
		bus(1'b1, ADDR_LOCK, LOCK_KEY);
		bus(1'b0, ADDR_LOCK, LOCK_KEY);
		bus(1'b1, ADDR_THRESH, 8'h12);
		chk(8'h12, thr);
		bus(1'b1, ADDR_LOCK, 8'h4b);
		bus(1'b0, ADDR_LOCK, 8'h00);
		bus(1'b1, ADDR_THRESH, 8'h34);
		chk(8'h12, thr);
		bus(1'b1, ADDR_IFC, 8'h53);
		chk(1'b1, hs);
		scl = 1'b0;
		for (n = 0; n < 60 && if_rst !== 1'b1; n++) @(negedge clk);
		chk(1'b1, n >= 20 && n <= 28);
		cyc(40);
		chk(8'd1, 8'(pulses));
		scl = 1'b1;
		bus(1'b1, ADDR_IFC, 8'h43);
		scl = 1'b0;
		cyc(60);
		chk(8'd1, 8'(pulses));
		scl = 1'b1;
		foreach (pn[i]) begin
			bus(1'b1, ADDR_PAD, {pn[i], 4'hd});
			cyc(2);
			chk({pe[i], 4'b0110}, {poe[1], pout[1], ppu[1], ppd[1], 1'b0, ppu[0], ppd[0], poe[0]});
		end
		chk(1'b1, irq_n);
		pin_in[0] = 1'b1;
		cyc(6);
		chk(1'b0, irq_n);
		bus(1'b0, ADDR_FLAGS, 8'h01);
		bus(1'b1, ADDR_FLAGS, 8'h01);
		pin_in[0] = 1'b0;
		cyc(6);
		bus(1'b0, ADDR_FLAGS, 8'h00);
		chk(1'b1, irq_n);
		exp_f = 8'h00;
		repeat (6) begin
			seed = xs(seed);
			exp_f |= {1'b0, seed[1] & ~pw[1], seed[0] & ~pw[0], 1'b0, seed[2] & ~pw[2], 3'b000};
			pw = seed[2:0];
			{oc, tmp, vb} = pw;
			cyc(6);
			bus(1'b0, ADDR_STATUS, {pw, 5'b00100});
			bus(1'b0, ADDR_FLAGS, exp_f);
		end
		bus(1'b1, ADDR_FLAGS, 8'h00);
		bus(1'b0, ADDR_FLAGS, exp_f);
		bus(1'b1, ADDR_MASK, 8'hff);
		bus(1'b0, ADDR_MASK, 8'h7f);
		// a write while the clock enable is low must leave the mask alone
		ce = 1'b0;
		bus(1'b1, ADDR_MASK, 8'h00);
		ce = 1'b1;
		bus(1'b0, ADDR_MASK, 8'h7f);
		cyc(2);
		chk(1'b1, irq_n);
		bus(1'b1, ADDR_MASK, 8'h00);
		cyc(2);
		chk(exp_f != 8'h00 ? 1'b0 : 1'b1, irq_n);
		bus(1'b1, ADDR_FLAGS, 8'hff);
		{oc, tmp, vb} = 3'b000;
		bus(1'b0, ADDR_FLAGS, 8'h00);
		pg = 1'b0;
		cyc(2);
		bus(1'b0, ADDR_STATUS, 8'h00);
		bus(1'b0, ADDR_FLAGS, 8'h04);
		pg = 1'b1;
		bus(1'b1, ADDR_FLAGS, 8'h04);
		// eight-tick debounce: a four-cycle blip must not pass
		bus(1'b1, ADDR_KEY, 8'h02);
		btn.hold(1'b0, 4);
		btn.hold(1'b1, 20);
		bus(1'b0, ADDR_FLAGS, 8'h00);
		btn.hold(1'b0, 20);
		bus(1'b0, ADDR_STATUS, 8'h0c);
		bus(1'b0, ADDR_FLAGS, 8'h10);
		bus(1'b1, ADDR_FLAGS, 8'h10);
		bus(1'b1, ADDR_KEY, 8'h0a);
		btn.hold(1'b1, 20);
		bus(1'b0, ADDR_FLAGS, 8'h10);
		en_mode = 1'b1;
		btn.hold(1'b0, 20);
		chk(1'b0, key_ce);
		btn.hold(1'b1, 20);
		chk(1'b1, key_ce);
		en_mode = 1'b0;
		bus(1'b1, ADDR_KEY, 8'h42);
		bus(1'b1, ADDR_MASK, 8'h7f);
		bus(1'b1, ADDR_FLAGS, 8'hff);
		btn.hold(1'b0, 0);
		for (n = 0; n < 41000 && irq_n !== 1'b0; n++) @(negedge clk);
		chk(1'b1, n > 39990 && n < 40030);
		for (n = 0; n < 8100 && pc_req !== 1'b1; n++) @(negedge clk);
		chk(1'b1, n > 7990 && n < 8010);
		bus(1'b0, ADDR_LOG, 8'h10);
		bus(1'b0, ADDR_FLAGS, 8'h90);
		btn.hold(1'b1, 20);
		seed = xs(seed);
		@(negedge clk);
		cause = seed[7:0];
		@(negedge clk);
		cause = 8'h00;
		bus(1'b0, ADDR_LOG, seed[7:0] | 8'h10);
		bus(1'b1, ADDR_LOG, 8'h00);
		bus(1'b0, ADDR_LOG, 8'h00);
		// pin 0 idle and pin 1 active on one function: pin 0 must win
		f0 = FN_EN;
		f1 = FN_EN;
		cyc(3);
		chk(8'h00, fo);
		f1 = FN_SLP;
		cyc(3);
		chk(8'h02, fo);
		f0 = FN_PWC;
		pin_in[0] = 1'b1;
		cyc(4);
		chk(8'h06, fo);
		bus(1'b1, ADDR_IFC, 8'h4b);
		pin_in[0] = 1'b0;
		cyc(4);
		bus(1'b1, ADDR_FLAGS, 8'hff);
		// one-cycle blip is filtered, two cycles pass
		pin_in[0] = 1'b1;
		cyc(1);
		pin_in[0] = 1'b0;
		cyc(6);
		bus(1'b0, ADDR_FLAGS, 8'h00);
		pin_in[0] = 1'b1;
		cyc(2);
		pin_in[0] = 1'b0;
		cyc(6);
		bus(1'b0, ADDR_FLAGS, 8'h01);
		wrap_up;
	end

	// the sequence needs about 49000 cycles
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		wrap_up;
	end
endmodule
`default_nettype wire
